// ==== rtl/pbo_cfg.svh ====
// Purpose: Constants for the phase-loss and build-out offset control block
// Assumes: AXI4-Lite byte addresses; printed offsets are register indices
// Notes:   Index 0x72 is printed; the other indices are chosen locally
`ifndef PBO_CFG_SVH
`define PBO_CFG_SVH
`define PBO_IDX_OFFSET     8'h72
`define PBO_IDX_FINE       8'h73
`define PBO_IDX_STATUS     8'h80
`define PBO_IDX_MASK       8'h81
`define PBO_IDX_PHERR      8'h82
`define PBO_ADDR_OFFSET    12'h1C8
`define PBO_ADDR_FINE      12'h1CC
`define PBO_ADDR_STATUS    12'h200
`define PBO_ADDR_MASK      12'h204
`define PBO_ADDR_PHERR     12'h208
`define PBO_RST_OFFSET     8'h00
`define PBO_RST_FINE       8'hA2
`define PBO_RST_MASK       2'h0
`define PBO_BIT_FINE_EN    7
`define PBO_BIT_NOACT      6
`define PBO_BIT_NARROW     5
`define PBO_FINE_MSB       2
`define PBO_OFS_MSB        5
`define PBO_FINE_SHIFT     5
`define PBO_RESP_OKAY      2'h0
`define PBO_RESP_SLVERR    2'h2
`endif

// ==== rtl/pbo_pkg.sv ====
// Purpose: Types for the phase-loss and build-out offset control block
// Assumes: Used with pbo_cfg.svh for constants
// Notes:   Lock state codes change one bit per step, except hold to acquire (two bits)
package pbo_pkg;
   typedef enum logic [1:0] {
      PBO_ACQUIRE = 2'h0,  // Full +-360 degree acquisition
      PBO_LOCKED  = 2'h1,  // Phase locked
      PBO_HOLDEDG = 2'h3   // Input gone, lock kept, nearest-edge relock
   } pbo_lock_t;
endpackage : pbo_pkg

// ==== rtl/pbo_regs_if.sv ====
// Purpose: Carrier between register slave and detector
// Assumes: Single clock
// Notes:   Configuration in, status out
`timescale 1ns/1ps
`default_nettype none
interface pbo_regs_if;
   logic [7:0] offset_cfg;
   logic [7:0] fine_cfg;
   logic       loss_event;
   logic       lock_event;
   logic       phase_lost;
   modport regs (output offset_cfg, output fine_cfg, input loss_event, input lock_event,
                 input phase_lost);
   modport det  (input offset_cfg, input fine_cfg, output loss_event, output lock_event,
                 output phase_lost);
endinterface : pbo_regs_if
`default_nettype wire

// ==== rtl/pbo_detect.sv ====
// Purpose: Phase-loss decision and build-out offset application
// Assumes: Phase error magnitude and activity are synchronous inputs
// Notes:   Fine limit scales with the 3-bit field
`timescale 1ns/1ps
`default_nettype none
`include "pbo_cfg.svh"
module pbo_detect (
   input  wire logic         aclk,          // System clock
   input  wire logic         aresetn,       // Sync reset, active low
   pbo_regs_if.det           rif,           // Configuration and events
   input  wire logic [15:0]  phase_err,     // Phase error magnitude
   input  wire logic         other_loss,    // Other internal loss means
   input  wire logic         ref_active,    // Reference activity seen
   input  wire logic         pbo_event,     // Build-out event strobe
   input  wire logic [15:0]  pbo_phase,     // Raw build-out phase
   output logic              pbo_valid,     // Offset phase valid
   output logic      [15:0]  pbo_adj,       // Offset-corrected phase
   output logic              nearest_edge,  // Relock within +-180 degrees
   output logic              full_acq       // Acquire over +-360 degrees
);
   pbo_pkg::pbo_lock_t state;
   pbo_pkg::pbo_lock_t next_state;
   logic        fine_en;
   logic        noact_en;
   logic [15:0] fine_lim;
   logic        fine_trip;
   logic        noact_trip;
   logic        lose;
   logic [15:0] ofs_ext;

   assign fine_en    = rif.fine_cfg[`PBO_BIT_FINE_EN];
   assign noact_en   = rif.fine_cfg[`PBO_BIT_NOACT];
   assign fine_lim   = {8'h00, 5'h00, rif.fine_cfg[`PBO_FINE_MSB:0]} << `PBO_FINE_SHIFT;
   assign fine_trip  = fine_en && (phase_err > fine_lim);
   assign noact_trip = noact_en && !ref_active;
   assign lose       = fine_trip || noact_trip || other_loss;
   // Sign-extend the six-bit offset
   assign ofs_ext    = {{10{rif.offset_cfg[`PBO_OFS_MSB]}},
                        rif.offset_cfg[`PBO_OFS_MSB:0]};

   always_comb begin
      next_state = state;
      case (state)
         pbo_pkg::PBO_ACQUIRE: if (!lose && ref_active) next_state = pbo_pkg::PBO_LOCKED;
         pbo_pkg::PBO_LOCKED: begin
            if (lose) next_state = pbo_pkg::PBO_ACQUIRE;
            else if (!ref_active) next_state = pbo_pkg::PBO_HOLDEDG;
         end
         pbo_pkg::PBO_HOLDEDG: begin
            if (lose) next_state = pbo_pkg::PBO_ACQUIRE;
            else if (ref_active) next_state = pbo_pkg::PBO_LOCKED;
         end
         default: next_state = pbo_pkg::PBO_ACQUIRE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state <= pbo_pkg::PBO_ACQUIRE;
      else state <= next_state;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pbo_valid <= 1'b0;
         pbo_adj   <= 16'h0000;
      end else begin
         pbo_valid <= pbo_event;
         if (pbo_event) pbo_adj <= pbo_phase + ofs_ext;
      end
   end

   assign rif.phase_lost = (state == pbo_pkg::PBO_ACQUIRE);
   assign rif.loss_event = (state != pbo_pkg::PBO_ACQUIRE) && (next_state == pbo_pkg::PBO_ACQUIRE);
   assign rif.lock_event = (state == pbo_pkg::PBO_ACQUIRE) && (next_state == pbo_pkg::PBO_LOCKED);
   assign full_acq       = (state == pbo_pkg::PBO_ACQUIRE);
   assign nearest_edge   = (state == pbo_pkg::PBO_HOLDEDG);

   fine_loss_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state != pbo_pkg::PBO_ACQUIRE && fine_en && phase_err > fine_lim)
      |=> state == pbo_pkg::PBO_ACQUIRE) else $error("fine limit did not cause loss");
   noact_loss_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state != pbo_pkg::PBO_ACQUIRE && noact_en && !ref_active)
      |=> full_acq) else $error("inactivity did not cause loss");
   hold_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == pbo_pkg::PBO_LOCKED && !ref_active && !noact_en && !other_loss && !fine_trip)
      |=> nearest_edge && !full_acq) else $error("lock dropped on inactivity");
   no_fine_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == pbo_pkg::PBO_LOCKED && !fine_en && ref_active && !other_loss)
      |=> state == pbo_pkg::PBO_LOCKED) else $error("loss without cause");
   offset_add_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pbo_event |=> pbo_valid && pbo_adj == $past(pbo_phase) + $past(ofs_ext))
      else $error("build-out offset not applied");
   sign_ext_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ofs_ext[15] == rif.offset_cfg[5]) else $error("offset not signed");
   acq_lost_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rif.phase_lost |-> full_acq && !nearest_edge) else $error("acquire mode wrong");
   hold_cov_c: cover property (@(posedge aclk) nearest_edge ##[1:20] state == pbo_pkg::PBO_LOCKED);
   loss_cov_c: cover property (@(posedge aclk) rif.loss_event);
   pbo_cov_c:  cover property (@(posedge aclk) pbo_valid && ofs_ext[15]);
endmodule : pbo_detect
`default_nettype wire

// ==== rtl/pbo_top.sv ====
// Functional notes
// - Build-out offset register is read/write and resets to zero.
// - Programmed offset is added to every phase build-out event.
// - Fine enable set: phase error beyond fine limit declares phase loss.
// - Default: input failure keeps lock; relock to nearest edge within half cycle.
// - Declared phase loss forces full frequency and phase acquisition.
// - Inactivity bit set: no reference activity declares phase loss at once.
//
// Purpose: AXI4-Lite top of phase-loss and build-out offset control
// Assumes: Single 100 MHz clock, synchronous active-low reset
// Notes:   Status bit 0 loss, bit 1 lock; write one to clear
`timescale 1ns/1ps
`default_nettype none
`include "pbo_cfg.svh"
module pbo_top (
   input  wire logic         aclk,          // System clock
   input  wire logic         aresetn,       // Sync reset, active low
   input  wire logic [11:0]  s_axi_awaddr,  // Write address
   input  wire logic         s_axi_awvalid, // Write address valid
   output logic              s_axi_awready, // Write address ready
   input  wire logic [31:0]  s_axi_wdata,   // Write data
   input  wire logic [3:0]   s_axi_wstrb,   // Write strobes
   input  wire logic         s_axi_wvalid,  // Write data valid
   output logic              s_axi_wready,  // Write data ready
   output logic [1:0]        s_axi_bresp,   // Write response
   output logic              s_axi_bvalid,  // Write response valid
   input  wire logic         s_axi_bready,  // Write response ready
   input  wire logic [11:0]  s_axi_araddr,  // Read address
   input  wire logic         s_axi_arvalid, // Read address valid
   output logic              s_axi_arready, // Read address ready
   output logic [31:0]       s_axi_rdata,   // Read data
   output logic [1:0]        s_axi_rresp,   // Read response
   output logic              s_axi_rvalid,  // Read data valid
   input  wire logic         s_axi_rready,  // Read data ready
   input  wire logic [15:0]  phase_err,     // Phase error magnitude
   input  wire logic         other_loss,    // Other loss detection
   input  wire logic         ref_active,    // Reference activity
   input  wire logic         pbo_event,     // Build-out event strobe
   input  wire logic [15:0]  pbo_phase,     // Raw build-out phase
   output logic              pbo_valid,     // Offset phase valid
   output logic [15:0]       pbo_adj,       // Offset-corrected phase
   output logic              nearest_edge,  // Nearest-edge relock mode
   output logic              full_acq,      // Full acquisition mode
   output logic              phase_lost,    // Phase loss declared
   output logic              irq            // Interrupt, level
);
   pbo_regs_if rif ();
   logic [7:0]  offset_cfg;
   logic [7:0]  fine_cfg;
   logic [1:0]  status;
   logic [1:0]  mask;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_have;
   logic        w_have;
   logic        do_write;
   logic [1:0]  events;
   logic [1:0]  w1c;
   logic [1:0]  next_mask;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic        rd_hit;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == `PBO_ADDR_OFFSET) || (a == `PBO_ADDR_FINE) ||
                   (a == `PBO_ADDR_STATUS) || (a == `PBO_ADDR_MASK) ||
                   (a == `PBO_ADDR_PHERR);
   endfunction : addr_known

   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready  = !w_have && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_have && w_have && !s_axi_bvalid;
   assign wr_hit   = do_write && w_strb[0];
   assign w1c      = (wr_hit && aw_addr == `PBO_ADDR_STATUS) ? w_data[1:0] : 2'h0;
   assign events   = {rif.lock_event, rif.loss_event};
   // Mask as it stands after this edge, so irq follows a mask write at once
   assign next_mask = (wr_hit && aw_addr == `PBO_ADDR_MASK) ? w_data[1:0] : mask;
   assign rd_hit   = addr_known(s_axi_araddr);
   assign rd_word  = (s_axi_araddr == `PBO_ADDR_OFFSET) ? {24'h000000, offset_cfg} :
                     (s_axi_araddr == `PBO_ADDR_FINE)   ? {24'h000000, fine_cfg} :
                     (s_axi_araddr == `PBO_ADDR_STATUS) ? {30'h00000000, status} :
                     (s_axi_araddr == `PBO_ADDR_MASK)   ? {30'h00000000, mask} :
                     (s_axi_araddr == `PBO_ADDR_PHERR)  ?
                        {29'h00000000, nearest_edge, full_acq, phase_lost} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have  <= 1'b0;
         aw_addr <= 12'h000;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) aw_have <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) w_have <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PBO_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= addr_known(aw_addr) ? `PBO_RESP_OKAY : `PBO_RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offset_cfg <= `PBO_RST_OFFSET;
         fine_cfg   <= `PBO_RST_FINE;
         mask       <= `PBO_RST_MASK;
      end else if (wr_hit) begin
         // Unused bits 7:6 of the offset register stay zero
         if (aw_addr == `PBO_ADDR_OFFSET) offset_cfg <= {2'h0, w_data[5:0]};
         // Software keeps fine enable low for multi-UI jitter tolerance
         if (aw_addr == `PBO_ADDR_FINE) fine_cfg <= w_data[7:0];
         if (aw_addr == `PBO_ADDR_MASK) mask <= w_data[1:0];
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge aclk) begin
      if (!aresetn) status <= 2'h0;
      else status <= (status & ~w1c) | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PBO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? `PBO_RESP_OKAY : `PBO_RESP_SLVERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end

   function automatic logic [1:0] next_status_masked(input logic [1:0] s, input logic [1:0] c,
                                                     input logic [1:0] e, input logic [1:0] m);
      next_status_masked = ((s & ~c) | e) & m;
   endfunction : next_status_masked

   always_ff @(posedge aclk) begin
      if (!aresetn) irq <= 1'b0;
      else irq <= |(next_status_masked(status, w1c, events, next_mask));
   end

   assign rif.offset_cfg = offset_cfg;
   assign rif.fine_cfg   = fine_cfg;
   assign phase_lost     = rif.phase_lost;

   pbo_detect u_det (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .rif          (rif),
      .phase_err    (phase_err),
      .other_loss   (other_loss),
      .ref_active   (ref_active),
      .pbo_event    (pbo_event),
      .pbo_phase    (pbo_phase),
      .pbo_valid    (pbo_valid),
      .pbo_adj      (pbo_adj),
      .nearest_edge (nearest_edge),
      .full_acq     (full_acq)
   );

   offset_reset_a: assert property (@(posedge aclk)
      !aresetn |=> offset_cfg == 8'h00) else $error("offset not zero after reset");
   offset_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_hit && aw_addr == `PBO_ADDR_OFFSET |=> offset_cfg[5:0] == $past(w_data[5:0]))
      else $error("offset write lost");
   set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      |events |=> (status & $past(events)) == $past(events)) else $error("event lost");
   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      irq == |(status & mask)) else $error("irq mismatch");
   wr_cov_c: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
   rd_cov_c: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
endmodule : pbo_top
`default_nettype wire

// ==== tb/pbo_ref_model.sv ====
// Purpose: Reference-side model feeding the phase detector
// Assumes: The bench commands it through its two tasks
// Notes:   Raw phase bus is scrambled outside strobe cycles
`timescale 1ns/1ps
`default_nettype none
module pbo_ref_model (
   input  wire logic        aclk,       // System clock
   output logic      [15:0] phase_err,  // Phase error magnitude
   output logic             other_loss, // Other loss cause
   output logic             ref_active, // Reference present
   output logic             pbo_event,  // Build-out strobe
   output logic      [15:0] pbo_phase   // Raw build-out phase
);
   initial begin
      phase_err  = 16'h0000;
      other_loss = 1'b0;
      ref_active = 1'b0;
      pbo_event  = 1'b0;
      pbo_phase  = 16'hA5A5;
   end
   task automatic set_ref(input logic a, input logic [15:0] e, input logic o);
      @(posedge aclk);
      ref_active <= a;
      phase_err  <= e;
      other_loss <= o;
   endtask : set_ref
   task automatic fire(input logic [15:0] ph);
      @(posedge aclk);
      pbo_event <= 1'b1;
      pbo_phase <= ph;
      @(posedge aclk);
      pbo_event <= 1'b0;
      pbo_phase <= ~ph;  // Stale phase must not look valid
   endtask : fire
endmodule : pbo_ref_model
`default_nettype wire

// ==== tb/pbo_top_tb_top.sv ====
// Purpose: Self-checking bench of the phase-loss and build-out block
// Assumes: AXI4-Lite master tasks, reference model drives detector
// Notes:   Handshakes are peeked at the falling edge, taken at the rising
`timescale 1ns/1ps
`default_nettype none
`include "pbo_cfg.svh"
module pbo_top_tb_top;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, other_loss, ref_active;
   logic        pbo_event, pbo_valid, nearest_edge, full_acq, phase_lost, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, q;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] phase_err, pbo_phase, pbo_adj;
   int          n_mismatch, checks_done;
   pbo_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .phase_err(phase_err), .other_loss(other_loss),
      .ref_active(ref_active), .pbo_event(pbo_event), .pbo_phase(pbo_phase),
      .pbo_valid(pbo_valid), .pbo_adj(pbo_adj), .nearest_edge(nearest_edge),
      .full_acq(full_acq), .phase_lost(phase_lost), .irq(irq));
   pbo_ref_model u_ref (.aclk(aclk), .phase_err(phase_err), .other_loss(other_loss),
      .ref_active(ref_active), .pbo_event(pbo_event), .pbo_phase(pbo_phase));
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic at, wt, art, done;
      @(posedge aclk);
      done = 1'b0;
      if (w) begin
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         bready  <= 1'b1;
      end else begin
         araddr  <= a;
         arvalid <= 1'b1;
         rready  <= 1'b1;
      end
      for (int n = 0; n < 40 && !done; n++) begin
         @(negedge aclk);
         at   = awvalid & awready;
         wt   = wvalid & wready;
         art  = arvalid & arready;
         done = (bvalid & bready) | (rvalid & rready);
         q    = rdata;
         r    = w ? bresp : rresp;
         @(posedge aclk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         if (art) arvalid <= 1'b0;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      chk("bus_answer", done, 1);
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      chk("bresp", r, `PBO_RESP_OKAY);
   endtask : wr
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("rresp", r, `PBO_RESP_OKAY);
      chk(nm, q, e);
   endtask : rd
   task automatic step(input logic a, input logic [15:0] e, input logic o);
      u_ref.set_ref(a, e, o);
      repeat (3) @(posedge aclk);
   endtask : step
   task automatic pins(input logic l, input logic f, input logic n);
      @(negedge aclk);
      chk("phase_lost", phase_lost, l);
      chk("full_acq", full_acq, f);
      chk("nearest_edge", nearest_edge, n);
   endtask : pins
   task automatic t_reset;
      pins(1, 1, 0);
      chk("irq", irq, 0);
      rd("offset_cfg", `PBO_ADDR_OFFSET, 32'h0);
      rd("fine_cfg", `PBO_ADDR_FINE, 32'hA2);
      rd("mask", `PBO_ADDR_MASK, 32'h0);
      rd("state", `PBO_ADDR_PHERR, 32'h3);
   endtask : t_reset
   task automatic t_offset;
      logic [7:0]  ov [4] = '{8'h3F, 8'h1F, 8'h20, 8'hC1};
      logic [15:0] pv [4] = '{16'h1000, 16'h1000, 16'h0010, 16'hFFFF};
      logic [15:0] ex;
      for (int i = 0; i < 4; i++) begin
         // Sum kept at 16 bits so the carry wraps as in hardware
         ex = pv[i] + {{10{ov[i][5]}}, ov[i][5:0]};
         wr(`PBO_ADDR_OFFSET, {24'h0, ov[i]});
         rd("offset_cfg", `PBO_ADDR_OFFSET, {26'h0, ov[i][5:0]});
         u_ref.fire(pv[i]);
         @(negedge aclk);
         chk("pbo_valid", pbo_valid, 1);
         chk("pbo_adj", pbo_adj, {16'h0000, ex});
         @(negedge aclk);
         chk("pbo_valid_end", pbo_valid, 0);
      end
      wr(`PBO_ADDR_OFFSET, 32'h0);
   endtask : t_offset
   task automatic t_fine;
      wr(`PBO_ADDR_STATUS, 32'h3);
      step(1, 16'h0000, 0);
      pins(0, 0, 0);
      rd("status_lock", `PBO_ADDR_STATUS, 32'h2);
      wr(`PBO_ADDR_MASK, 32'h1);
      rd("mask", `PBO_ADDR_MASK, 32'h1);
      chk("irq_masked", irq, 0);
      step(1, 16'd64, 0);
      pins(0, 0, 0);
      step(1, 16'd65, 0);
      pins(1, 1, 0);
      chk("irq_loss", irq, 1);
      step(1, 16'h0000, 0);
      rd("status_both", `PBO_ADDR_STATUS, 32'h3);
      wr(`PBO_ADDR_STATUS, 32'h1);
      rd("status_clr", `PBO_ADDR_STATUS, 32'h2);
      chk("irq_clr", irq, 0);
   endtask : t_fine
   task automatic t_fine_off;
      wr(`PBO_ADDR_FINE, 32'h02);
      step(1, 16'hFFFF, 0);
      pins(0, 0, 0);
      step(1, 16'hFFFF, 1);
      pins(1, 1, 0);
      step(1, 16'h0000, 0);
      pins(0, 0, 0);
      wr(`PBO_ADDR_FINE, 32'hA2);
   endtask : t_fine_off
   task automatic t_hold;
      step(0, 16'h0000, 0);
      pins(0, 0, 1);
      rd("state_hold", `PBO_ADDR_PHERR, 32'h4);
      step(1, 16'h0000, 0);
      pins(0, 0, 0);
   endtask : t_hold
   task automatic t_noact;
      wr(`PBO_ADDR_FINE, 32'hC2);
      step(0, 16'h0000, 0);
      pins(1, 1, 0);
      rd("state_acq", `PBO_ADDR_PHERR, 32'h3);
      step(1, 16'h0000, 0);
      wr(`PBO_ADDR_FINE, 32'hA2);
   endtask : t_noact
   task automatic t_unmapped;
      bus(1'b0, 12'h300, 32'h0);
      chk("rresp_bad", r, `PBO_RESP_SLVERR);
      chk("rdata_bad", q, 0);
      bus(1'b1, 12'h300, 32'h5);
      chk("bresp_bad", r, `PBO_RESP_SLVERR);
   endtask : t_unmapped
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      end_sim();
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_offset();
      t_fine();
      t_fine_off();
      t_hold();
      t_noact();
      t_unmapped();
      end_sim();
   end
endmodule : pbo_top_tb_top
`default_nettype wire
